// *** logic/multiturn_pkg.sv ***
package multiturn_pkg;
	// Position format: signed turns above a 14-bit fraction of one turn
	localparam int FRAC_W = 14;
	localparam int POS_W = 21;
	localparam int TURN = 16384;
	localparam int HALF_TURN = 8192;
	localparam int TC_W = 6;
	localparam int SIN_W = 12;

	// Derived turn count span and wrap limits
	localparam int TURN_MIN = -9;
	localparam int TURN_MAX = 54;
	localparam logic signed [POS_W-1:0] POS_WRAP_HI = POS_W'((TURN_MAX + 1) * TURN);
	localparam logic signed [POS_W-1:0] POS_WRAP_LO = POS_W'(TURN_MIN * TURN);
	localparam logic signed [POS_W-1:0] POS_ONE_TURN = POS_W'(TURN);
	localparam logic signed [POS_W-1:0] POS_HALF = POS_W'(HALF_TURN);

	// Power-off span check limits (46.5 and 0 turns)
	localparam logic signed [POS_W-1:0] POS_CHECK_HI = POS_W'(46 * TURN + HALF_TURN);
	localparam logic signed [POS_W-1:0] POS_CHECK_LO = POS_W'(0);

	// Filter bypass hysteresis (53.5/53 and -8.5/-8 turns)
	localparam logic signed [POS_W-1:0] BYP_HI_SET = POS_W'(53 * TURN + HALF_TURN);
	localparam logic signed [POS_W-1:0] BYP_HI_CLR = POS_W'(53 * TURN);
	localparam logic signed [POS_W-1:0] BYP_LO_SET = POS_W'(-8 * TURN - HALF_TURN);
	localparam logic signed [POS_W-1:0] BYP_LO_CLR = POS_W'(-8 * TURN);
	localparam int FILT_SHIFT = 4;

	// General configuration bit positions
	localparam int GEN_MODE_BIT = 0;
	localparam int GEN_FILT_BIT = 12;

	// Convert control field codes
	localparam logic [1:0] CNV_START = 2'h0;
	localparam logic [1:0] CNV_ABORT = 2'h3;

	// Fault bit positions
	localparam int F_NVM_CRC = 5;
	localparam int F_ECC_DBL = 7;
	localparam int F_TURN_ILL = 9;
	localparam int F_XCHECK = 13;
	localparam int F_RADIUS = 14;
	localparam logic [15:0] FAULT_RST = 16'h0000;

	// Nonvolatile copy layout
	localparam int NVM_WORDS = 8;
	localparam int NVM_IDX_W = 3;
	localparam int NVM_RADIUS_IDX = 0;
	localparam int NVM_GMR_CFG_IDX = 1;
	localparam logic [15:0] GMR_CFG_LEGAL = 16'h00FF;
	localparam logic [7:0] CRC_SEED = 8'hFF;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam int ECC_W = 6;

	typedef enum logic [2:0] {BOOT, BOOT_FAIL, IDLE, WAIT_TURN, ANGLE} seq_state_t;

	typedef struct packed {
		logic valid;
		logic [TC_W-1:0] count;
		logic [TC_W-1:0] count_redundant;
		logic illegal;
		logic quadrant_err;
		logic combine_err;
	} turn_sample_t;

	typedef struct packed {
		logic valid;
		logic [FRAC_W-1:0] frac;
		logic signed [SIN_W-1:0] sin_diff;
		logic signed [SIN_W-1:0] cos_diff;
	} angle_sample_t;
endpackage

// *** logic/multiturn_position_diagnostics.sv ***
`timescale 1ns/1ns

// What this block does
// [R1] Turn sensor reference: one-shot always, continuous first
// [R2] Derived turn count spans minus nine to 54
// [R3] Power-off position valid only zero to 46
// [R4] Decode turn sensor once per sequence, verify
// [R5] Past limits, position wraps within one turn
// [R6] Mismatch over half turn sets cross-check fault
// [R7] No cross-check fault in one-shot or unpowered
// [R8] Count above 46.5 or below zero faults
// [R9] Decoder, combination or quadrant errors fault
// [R10] Angle filter runs only when enabled
// [R11] Output moves one sixteenth toward sample
// [R12] Bypass above 53.5 until below 53
// [R13] Bypass below -8.5 until above -8
// [R14] Host avoids filter in one-shot mode
// [R15] Illegal turn sensor state sets fault
// [R16] Radius over factory limit sets fault
// [R17] Load NVM copy with SECDED correction
// [R18] Double error: halt, boot output high, fault
// [R19] Continuous CRC check of loaded copy
// [R20] User config ECC, double error faults
// [R21] Host resets turn counter on those faults
// [R22] Restart after reset reloads turn reference
// [R23] Mode bit zero continuous, one one-shot
// [R24] Convert field: 11 aborts, 00 starts
module multiturn_position_diagnostics
	import multiturn_pkg::*;
#(
	parameter int ANGLES_PER_SEQ = 8
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Configuration and control
	input wire logic [15:0] general_config_i,
	input wire logic [ECC_W-1:0] config_ecc_code_store_i,
	input wire logic [1:0] convert_control_i,
	input wire logic convert_control_wr_i,
	input wire logic [15:0] fault_clear_i,
	// Nonvolatile memory read port
	output logic [NVM_IDX_W-1:0] nvm_addr_o,
	input wire logic [15:0] nvm_data_i,
	input wire logic [ECC_W-1:0] nvm_check_i,
	// Sensor results
	input wire turn_sample_t turn_i,
	input wire angle_sample_t angle_i,
	// Results and status
	output logic boot_load_pending_output_o,
	output logic busy_o,
	output logic seq_done_o,
	output logic signed [POS_W-1:0] position_o,
	output logic [FRAC_W-1:0] angle_o,
	output logic [1:0] conv_count_o,
	output logic [15:0] fault_o
);

	typedef struct packed {
		seq_state_t st;
		logic [NVM_IDX_W-1:0] load_idx;
		logic load_phase;
		logic [NVM_WORDS-1:0][15:0] shadow;
		logic [7:0] ref_crc;
		logic [NVM_IDX_W-1:0] scan_idx;
		logic [7:0] scan_crc;
		logic first_seq;
		logic one_shot_seq;
		logic [7:0] angle_cnt;
		logic [TC_W-1:0] gmr_turns;
		logic signed [POS_W-1:0] pos;
		logic [FRAC_W-1:0] prev_frac;
		logic [FRAC_W-1:0] filt;
		logic bypass;
		logic [FRAC_W-1:0] angle_out;
		logic [15:0] faults;
		logic [1:0] conv_count;
		logic done;
	} state_t;

	state_t s;
	state_t next_s;

	// Returns {double, single, corrected data}; single-bit faults are repaired
	function automatic logic [17:0] secded(input logic [15:0] d, input logic [ECC_W-1:0] c);
		logic [21:1] cw;
		logic [4:0] syn;
		logic par;
		logic [15:0] q;
		int j;
		int k;
		j = 0;
		k = 0;
		cw = '0;
		q = '0;
		for (int p = 1; p < 22; p++) begin
			if ((p & (p - 1)) == 0) begin
				cw[p] = c[k];
				k++;
			end else begin
				cw[p] = d[j];
				j++;
			end
		end
		syn = '0;
		for (int p = 1; p < 22; p++) begin
			if (cw[p]) begin
				syn = syn ^ 5'(p);
			end
		end
		par = (^cw) ^ c[ECC_W-1];
		if (par && syn != 5'h00 && syn < 5'h16) begin
			cw[syn] = ~cw[syn];
		end
		j = 0;
		for (int p = 1; p < 22; p++) begin
			if ((p & (p - 1)) != 0) begin
				q[j] = cw[p];
				j++;
			end
		end
		return {!par && syn != 5'h00, par, q};
	endfunction

	function automatic logic [7:0] crc_word(input logic [7:0] crc, input logic [15:0] w);
		logic [7:0] r;
		r = crc;
		for (int i = 15; i >= 0; i--) begin
			r = {r[6:0], 1'b0} ^ ((r[7] ^ w[i]) ? CRC_POLY : 8'h00);
		end
		return r;
	endfunction

	logic [17:0] nvm_dec;
	logic [17:0] cfg_dec;
	logic one_shot;
	logic filt_en;
	logic use_ref;
	logic signed [POS_W-1:0] gmr_pos;
	logic signed [POS_W-1:0] track_pos;
	logic signed [POS_W-1:0] new_pos;
	logic signed [POS_W-1:0] diff;
	logic signed [FRAC_W-1:0] step;
	logic signed [FRAC_W-1:0] fdelta;
	logic [2*SIN_W-1:0] sin_sq;
	logic [2*SIN_W-1:0] cos_sq;
	logic [31:0] radius_sq;
	logic [31:0] limit_sq;
	logic [15:0] set_f;

	always_comb begin
		nvm_dec = secded(nvm_data_i, nvm_check_i);
		// [R20] Config ECC check
		cfg_dec = secded(general_config_i, config_ecc_code_store_i);
		// [R23] Mode select bit
		one_shot = cfg_dec[GEN_MODE_BIT];
		filt_en = cfg_dec[GEN_FILT_BIT];
		// [R1] Reference choice
		use_ref = s.one_shot_seq || s.first_seq;
		gmr_pos = POS_W'(signed'({1'b0, s.gmr_turns}) * TURN) + POS_W'({1'b0, angle_i.frac});
		step = signed'(angle_i.frac - s.prev_frac);
		track_pos = s.pos + POS_W'(step);
		new_pos = (s.angle_cnt == 8'h00 && use_ref) ? gmr_pos : track_pos;
		// [R2] Span kept to minus nine through 54
		// [R5] Wrap within one turn at limits
		if (new_pos >= POS_WRAP_HI) begin
			new_pos = new_pos - POS_ONE_TURN;
		end else if (new_pos < POS_WRAP_LO) begin
			new_pos = new_pos + POS_ONE_TURN;
		end
		diff = track_pos - gmr_pos;
		fdelta = signed'(angle_i.frac - s.filt);
		// Squares are widened first so full-scale bridge values do not overflow
		sin_sq = (2*SIN_W)'(angle_i.sin_diff) * (2*SIN_W)'(angle_i.sin_diff);
		cos_sq = (2*SIN_W)'(angle_i.cos_diff) * (2*SIN_W)'(angle_i.cos_diff);
		radius_sq = 32'(sin_sq) + 32'(cos_sq);
		limit_sq = s.shadow[NVM_RADIUS_IDX] * s.shadow[NVM_RADIUS_IDX];

		next_s = s;
		next_s.done = 1'b0;
		set_f = '0;

		unique case (s.st)
			BOOT: begin
				// [R17] Copy NVM with single-bit correction
				if (!s.load_phase) begin
					next_s.load_phase = 1'b1;
				end else begin
					next_s.load_phase = 1'b0;
					next_s.shadow[s.load_idx] = nvm_dec[15:0];
					next_s.ref_crc = crc_word(s.ref_crc, nvm_dec[15:0]);
					next_s.load_idx = s.load_idx + 1'b1;
					// [R18] Double error halts boot
					if (nvm_dec[17]) begin
						set_f[F_ECC_DBL] = 1'b1;
						next_s.st = BOOT_FAIL;
					end else if (s.load_idx == NVM_IDX_W'(NVM_WORDS - 1)) begin
						next_s.st = WAIT_TURN;
						next_s.first_seq = 1'b1;
						next_s.one_shot_seq = one_shot;
					end
				end
			end
			BOOT_FAIL: begin
				set_f[F_ECC_DBL] = 1'b1;
			end
			IDLE: begin
				// [R24] Start code begins sequences
				// [R22] Restart reloads turn reference
				if (convert_control_wr_i && convert_control_i == CNV_START) begin
					next_s.st = WAIT_TURN;
					next_s.first_seq = 1'b1;
					next_s.one_shot_seq = one_shot;
				end
			end
			WAIT_TURN: begin
				// [R4] One decode per sequence
				if (turn_i.valid) begin
					next_s.gmr_turns = turn_i.count;
					next_s.angle_cnt = '0;
					next_s.st = ANGLE;
					// [R9] Decoder and logic errors
					set_f[F_XCHECK] = (turn_i.count != turn_i.count_redundant)
						|| turn_i.quadrant_err || turn_i.combine_err;
					// [R15] Illegal turn sensor state
					set_f[F_TURN_ILL] = turn_i.illegal;
				end
			end
			ANGLE: begin
				if (angle_i.valid) begin
					next_s.pos = new_pos;
					next_s.prev_frac = angle_i.frac;
					next_s.angle_cnt = s.angle_cnt + 8'h01;
					// [R16] Radius limit check
					set_f[F_RADIUS] = radius_sq > limit_sq;
					// [R4] Verify derived count once
					// [R6] Half-turn mismatch check
					// [R7] Not in one-shot mode
					if (s.angle_cnt == 8'h00 && !use_ref && !s.one_shot_seq) begin
						set_f[F_XCHECK] = diff > POS_HALF || diff < -POS_HALF;
					end
					// [R8] Outside power-off span
					// [R3] Only zero to 46 turns retained
					if (new_pos > POS_CHECK_HI || new_pos < POS_CHECK_LO) begin
						set_f[F_XCHECK] = 1'b1;
					end
					// [R12] Upper bypass hysteresis
					// [R13] Lower bypass hysteresis
					if (new_pos > BYP_HI_SET || new_pos < BYP_LO_SET) begin
						next_s.bypass = 1'b1;
					end else if (new_pos < BYP_HI_CLR && new_pos > BYP_LO_CLR) begin
						next_s.bypass = 1'b0;
					end
					// [R10] Filter only when enabled
					// [R11] Sixteenth step toward sample
					// [R14] One-shot use left to host
					if (filt_en && !s.bypass) begin
						next_s.filt = s.filt + FRAC_W'(fdelta >>> FILT_SHIFT);
					end else begin
						next_s.filt = angle_i.frac;
					end
					next_s.angle_out = (filt_en && !s.bypass)
						? s.filt + FRAC_W'(fdelta >>> FILT_SHIFT) : angle_i.frac;
					if (s.angle_cnt == 8'(ANGLES_PER_SEQ - 1)) begin
						next_s.done = 1'b1;
						next_s.conv_count = s.conv_count + 2'h1;
						next_s.first_seq = 1'b0;
						next_s.st = s.one_shot_seq ? IDLE : WAIT_TURN;
					end
				end
			end
			default: begin
				next_s.st = IDLE;
			end
		endcase

		// [R24] Abort code stops any running sequence
		if (convert_control_wr_i && convert_control_i == CNV_ABORT
				&& (s.st == WAIT_TURN || s.st == ANGLE)) begin
			next_s.st = IDLE;
			next_s.done = 1'b0;
		end

		// [R19] Background CRC scan of loaded copy
		if (s.st != BOOT && s.st != BOOT_FAIL) begin
			next_s.scan_crc = crc_word(s.scan_crc, s.shadow[s.scan_idx]);
			next_s.scan_idx = s.scan_idx + 1'b1;
			if (s.scan_idx == NVM_IDX_W'(NVM_WORDS - 1)) begin
				set_f[F_NVM_CRC] = next_s.scan_crc != s.ref_crc;
				next_s.scan_crc = CRC_SEED;
				next_s.scan_idx = '0;
			end
			// [R15] Factory turn sensor config must be legal
			if ((s.shadow[NVM_GMR_CFG_IDX] & ~GMR_CFG_LEGAL) != 16'h0000) begin
				set_f[F_TURN_ILL] = 1'b1;
			end
			// [R20] Config double error
			if (cfg_dec[17]) begin
				set_f[F_ECC_DBL] = 1'b1;
			end
		end

		// Set wins over a clear in the same cycle
		next_s.faults = (s.faults & ~fault_clear_i) | set_f;
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			s <= '0;
			s.st <= BOOT;
			s.ref_crc <= CRC_SEED;
			s.scan_crc <= CRC_SEED;
			s.faults <= FAULT_RST;
		end else begin
			s <= next_s;
		end
	end

	// [R18] Boot output stays high after a failed load
	assign boot_load_pending_output_o = s.st == BOOT || s.st == BOOT_FAIL;
	assign nvm_addr_o = s.load_idx;
	assign busy_o = s.st == WAIT_TURN || s.st == ANGLE;
	assign seq_done_o = s.done;
	assign position_o = s.pos;
	assign angle_o = s.angle_out;
	assign conv_count_o = s.conv_count;
	assign fault_o = s.faults;

endmodule // multiturn_position_diagnostics

// *** tb/multiturn_checker_assertions.sv ***
`timescale 1ns/1ns
module multiturn_checker
	import multiturn_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Watched ports
	input wire logic [15:0] general_config_i,
	input wire logic [1:0] convert_control_i,
	input wire logic convert_control_wr_i,
	input wire logic [15:0] fault_clear_i,
	input wire angle_sample_t angle_i,
	input wire logic boot_load_pending_output_o,
	input wire logic busy_o,
	input wire logic seq_done_o,
	input wire logic [FRAC_W-1:0] angle_o,
	input wire logic [1:0] conv_count_o,
	input wire logic [15:0] fault_o
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_load;
		boot_load_pending_output_o [*8];
	endsequence
	sequence s_halted;
		boot_load_pending_output_o && fault_o[F_ECC_DBL] && !busy_o;
	endsequence
	property p_load; !rst_i && $past(rst_i) |-> s_load; endproperty
	a_load: assert property (p_load) else $error("boot low in load");
	property p_busy; busy_o |-> !boot_load_pending_output_o; endproperty
	a_busy: assert property (p_busy) else $error("busy while booting");
	property p_halt; fault_o[F_ECC_DBL] && boot_load_pending_output_o |=> s_halted; endproperty
	a_halt: assert property (p_halt) else $error("left failed boot");
	property p_done; seq_done_o |-> conv_count_o == $past(conv_count_o) + 2'h1; endproperty
	a_done: assert property (p_done) else $error("count not stepped");
	property p_abort;
		convert_control_wr_i && convert_control_i == CNV_ABORT && busy_o |=> !busy_o;
	endproperty
	a_abort: assert property (p_abort) else $error("abort ignored");
	property p_start;
		convert_control_wr_i && convert_control_i == CNV_START && !busy_o
			&& !boot_load_pending_output_o |=> busy_o;
	endproperty
	a_start: assert property (p_start) else $error("start ignored");
	property p_hold; !angle_i.valid |=> $stable(angle_o); endproperty
	a_hold: assert property (p_hold) else $error("angle moved");
	property p_raw;
		!general_config_i[GEN_FILT_BIT] && angle_i.valid && busy_o
			|=> angle_o == $past(angle_i.frac);
	endproperty
	a_raw: assert property (p_raw) else $error("unfiltered angle wrong");
	property p_stick; fault_o[F_XCHECK] && !fault_clear_i[F_XCHECK] |=> fault_o[F_XCHECK]; endproperty
	a_stick: assert property (p_stick) else $error("fault lost");
endmodule // multiturn_checker

bind multiturn_position_diagnostics multiturn_checker chk (
	.ref_clk_i(ref_clk_i), .rst_i(rst_i), .general_config_i(general_config_i),
	.convert_control_i(convert_control_i), .convert_control_wr_i(convert_control_wr_i),
	.fault_clear_i(fault_clear_i), .angle_i(angle_i), .busy_o(busy_o),
	.boot_load_pending_output_o(boot_load_pending_output_o), .seq_done_o(seq_done_o),
	.angle_o(angle_o), .conv_count_o(conv_count_o), .fault_o(fault_o)
);

// *** tb/multiturn_position_diagnostics_tb.sv ***
`timescale 1ns/1ns
module multiturn_position_diagnostics_tb;
	import multiturn_pkg::*;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [15:0] cfg = 16'h0000;
	logic [5:0] cfg_ecc;
	logic [5:0] ecc_err = 6'h00;
	logic [1:0] code = 2'h0;
	logic wr = 1'b0;
	logic [15:0] clr = 16'h0000;
	logic dbl = 1'b0;
	logic [2:0] addr;
	logic [15:0] ndata;
	logic [5:0] ncheck;
	turn_sample_t ts = '0;
	angle_sample_t smp = '0;
	logic boot;
	logic busy;
	logic done;
	logic signed [POS_W-1:0] pos;
	logic [FRAC_W-1:0] ang;
	logic [1:0] cc;
	logic [15:0] fault;
	int failures = 0;
	int checks = 0;
	always #5 ref_clk_i = ~ref_clk_i;
	nvm_store_model nvm (
		.nvm_addr_i(addr), .double_err_i(dbl), .nvm_data_o(ndata), .nvm_check_o(ncheck),
		.cfg_i(cfg), .cfg_ecc_o(cfg_ecc)
	);
	multiturn_position_diagnostics #(.ANGLES_PER_SEQ(2)) dut (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .general_config_i(cfg),
		.config_ecc_code_store_i(cfg_ecc ^ ecc_err), .convert_control_i(code),
		.convert_control_wr_i(wr), .fault_clear_i(clr), .nvm_addr_o(addr),
		.nvm_data_i(ndata), .nvm_check_i(ncheck), .turn_i(ts), .angle_i(smp),
		.boot_load_pending_output_o(boot), .busy_o(busy), .seq_done_o(done),
		.position_o(pos), .angle_o(ang), .conv_count_o(cc), .fault_o(fault)
	);
	task automatic stop_test();
		if (failures == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			failures++;
			$display("mismatch at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask
	// Error bits: redundant decode, illegal state, quadrant
	task automatic turn(input logic [5:0] n, input logic [2:0] e);
		@(posedge ref_clk_i);
		ts <= '{1'b1, n, n ^ {5'h00, e[2]}, e[1], e[0], 1'b0};
		@(posedge ref_clk_i);
		ts.valid <= 1'b0;
	endtask
	task automatic angle(input logic [13:0] f, input logic [11:0] s);
		@(posedge ref_clk_i);
		smp <= '{1'b1, f, s, 12'h000};
		@(posedge ref_clk_i);
		smp.valid <= 1'b0;
		#1;
	endtask
	task automatic convert_control(input logic [1:0] c);
		@(posedge ref_clk_i);
		code <= c;
		wr <= 1'b1;
		@(posedge ref_clk_i);
		wr <= 1'b0;
		#1;
	endtask
	task automatic set_cfg(input logic [15:0] v);
		@(posedge ref_clk_i);
		cfg <= v;
	endtask
	task automatic clear();
		@(posedge ref_clk_i);
		clr <= 16'hFFFF;
		@(posedge ref_clk_i);
		clr <= 16'h0000;
		#1;
		chk(fault, FAULT_RST);
	endtask
	initial begin
		tick(3);
		chk(boot, 1'b1);
		chk(fault, FAULT_RST);
		@(posedge ref_clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 40 && busy !== 1'b1; i++) begin
			tick(1);
		end
		chk(busy, 1'b1);
		// A load that never finishes ends the run here
		if (busy !== 1'b1) begin
			stop_test();
		end
		chk(boot, 1'b0);
		turn(6'h05, 3'h0);
		angle(14'h03E8, 12'h000);
		chk(pos, 5 * TURN + 14'h03E8);
		chk(ang, 14'h03E8);
		angle(14'h044C, 12'h000);
		chk(done, 1'b1);
		chk(cc, 2'h1);
		turn(6'h09, 3'h0);
		angle(14'h04B0, 12'h000);
		chk(pos, 5 * TURN + 14'h04B0);
		chk(fault[F_XCHECK], 1'b1);
		angle(14'h04B0, 12'h000);
		clear();
		set_cfg(16'h1000);
		turn(6'h05, 3'h4);
		angle(14'h0AF0, 12'h000);
		chk(ang, 14'h0514);
		chk(fault[F_XCHECK], 1'b1);
		angle(14'h0AF0, 12'h000);
		chk(ang, 14'h0571);
		chk(pos, 5 * TURN + 14'h0AF0);
		clear();
		set_cfg(16'h0000);
		turn(6'h05, 3'h3);
		angle(14'h0AF0, 12'h7FF);
		chk(fault[F_RADIUS], 1'b1);
		chk(fault[F_TURN_ILL], 1'b1);
		chk(fault[F_XCHECK], 1'b1);
		angle(14'h0AF0, 12'h000);
		clear();
		convert_control(CNV_ABORT);
		chk(busy, 1'b0);
		set_cfg(16'h0001);
		convert_control(CNV_START);
		chk(busy, 1'b1);
		turn(6'h14, 3'h0);
		angle(14'h01F4, 12'h000);
		chk(pos, 20 * TURN + 14'h01F4);
		angle(14'h01F4, 12'h000);
		chk(busy, 1'b0);
		convert_control(CNV_START);
		turn(6'h1E, 3'h0);
		angle(14'h0258, 12'h000);
		chk(pos, 30 * TURN + 14'h0258);
		chk(fault[F_XCHECK], 1'b0);
		angle(14'h0258, 12'h000);
		set_cfg(16'h0000);
		convert_control(CNV_START);
		turn(6'h36, 3'h0);
		angle(14'h3E80, 12'h000);
		chk(pos, 54 * TURN + 14'h3E80);
		angle(14'h0190, 12'h000);
		chk(pos, 54 * TURN + 14'h0190);
		chk(fault[F_XCHECK], 1'b1);
		@(posedge ref_clk_i);
		ecc_err <= 6'h03;
		tick(3);
		chk(fault[F_ECC_DBL], 1'b1);
		@(posedge ref_clk_i);
		ecc_err <= 6'h00;
		dbl <= 1'b1;
		rst_i <= 1'b1;
		tick(3);
		@(posedge ref_clk_i);
		rst_i <= 1'b0;
		tick(24);
		chk(boot, 1'b1);
		chk(busy, 1'b0);
		chk(fault[F_ECC_DBL], 1'b1);
		stop_test();
	end
endmodule // multiturn_position_diagnostics_tb

// *** tb/nvm_store_model.sv ***
`timescale 1ns/1ns
module nvm_store_model
	import multiturn_pkg::*;
(
	// Word read port
	input wire logic [NVM_IDX_W-1:0] nvm_addr_i,
	input wire logic double_err_i,
	output logic [15:0] nvm_data_o,
	output logic [ECC_W-1:0] nvm_check_o,
	// Config check bits
	input wire logic [15:0] cfg_i,
	output logic [ECC_W-1:0] cfg_ecc_o
);
	function automatic logic [ECC_W-1:0] secded(input logic [15:0] d);
		logic [21:1] w;
		logic [ECC_W-1:0] c;
		int j;
		w = '0;
		c = '0;
		j = 0;
		for (int p = 1; p <= 21; p++) begin
			if ((p & (p - 1)) != 0) begin
				w[p] = d[j];
				j++;
			end
			for (int k = 0; k < 5; k++) begin
				if (p[k]) begin
					c[k] = c[k] ^ w[p];
				end
			end
		end
		c[5] = ^{d, c[4:0]};
		return c;
	endfunction
	logic [15:0] word;
	always_comb begin
		// Word 0 radius limit, word 1 legal sensor config
		case (nvm_addr_i)
			3'h0: word = 16'h0400;
			3'h1: word = 16'h0012;
			default: word = {13'h0A50, nvm_addr_i};
		endcase
		nvm_check_o = secded(word);
		// two flipped bits in word 3
		nvm_data_o = word ^ {14'h0000, {2{double_err_i && nvm_addr_i == 3'h3}}};
		cfg_ecc_o = secded(cfg_i);
	end
endmodule // nvm_store_model
